// ### design/cdmcg_pkg.sv
// Purpose: constants for the cpu slow-down and module clock gate block
// Assumes: 16-bit register port, one system clock
// Notes: offsets are word indices on the plain register port
package cdmcg_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [3:0] ADDR_DIV = 4'h0;
  localparam logic [3:0] ADDR_GATE = 4'h1;

  // ------------------------------------------------------------
  // clock divider register fields
  // ------------------------------------------------------------
  localparam int BIT_FAST_IRQ = 15;
  localparam int BIT_RATIO_HI = 14;
  localparam int BIT_RATIO_LO = 12;
  localparam int BIT_SLOW_EN = 11;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [2:0] RST_RATIO = 3'h0;
  localparam logic [6:0] RST_COUNT = 7'h00;

  // one instruction cycle equals one system clock here
  localparam int GATE_DELAY_CYC = 1;

endpackage

// ### design/cdmcg_top.sv
// Purpose: cpu slow-down divider and per-module clock gating
// Assumes: one 40 MHz clock, synchronous active high reset
// Notes: cpu clock is issued as a one-cycle enable pulse, module clocks as held enables
//
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module cdmcg_top #(
  parameter int NUM_MODS = 16,
  parameter logic [15:0] PRESENT = 16'hffff
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // register port
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWe,
  input wire logic regRe,
  output logic [15:0] regRdata,
  // interrupt event from the interrupt controller
  input wire logic irqEvent,
  // per-module own control enable
  input wire logic [NUM_MODS-1:0] modCtrlOn,
  // cpu clock enable, one pulse per cpu cycle
  output logic cpuClkEn,
  // peripheral clock enable, full rate
  output logic periphClkEn,
  // per-module clock and register access enables
  output logic [NUM_MODS-1:0] modClkEn,
  output logic [NUM_MODS-1:0] modRegOk
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic fastOnIrq;
    logic slowEn;
    logic [2:0] ratio;
    logic [2:0] actRatio;
    logic [6:0] divCnt;
    logic cpuEn;
    logic perEn;
    logic [NUM_MODS-1:0] gate;
    logic [NUM_MODS-1:0] modEn;
    logic [15:0] rdata;
  } cdmcg_state_s;

  cdmcg_state_s st_q;
  cdmcg_state_s st_d;

  logic [NUM_MODS-1:0] presMask;
  assign presMask = PRESENT[NUM_MODS-1:0];

  // address match for a strobe
  function automatic logic regHit(input logic stb, input logic [3:0] a,
                                  input logic [3:0] off);
    regHit = stb && (a == off);
  endfunction

  // terminal count for a divide by 2^r
  function automatic logic [6:0] divTop(input logic [2:0] r);
    divTop = 7'((8'h01 << r) - 8'h01);
  endfunction

  logic wrDiv;
  logic wrGate;
  logic wakeIrq;
  logic [2:0] effRatio;
  assign wrDiv = regHit(regWe, regAddr, cdmcg_pkg::ADDR_DIV);
  assign wrGate = regHit(regWe, regAddr, cdmcg_pkg::ADDR_GATE);
  assign wakeIrq = irqEvent && st_q.fastOnIrq && st_q.slowEn;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.perEn = 1'b1;
    // control register write
    if (wrDiv) begin
      st_d.fastOnIrq = regWdata[cdmcg_pkg::BIT_FAST_IRQ];
      st_d.slowEn = regWdata[cdmcg_pkg::BIT_SLOW_EN];
      st_d.ratio = regWdata[cdmcg_pkg::BIT_RATIO_HI:cdmcg_pkg::BIT_RATIO_LO];
    end
    // interrupt wake overrides the slow-down enable of a same-cycle write
    if (wakeIrq) begin
      st_d.slowEn = 1'b0;
    end
    // without wake nothing from irqEvent reaches the divider
    // ratio in force: full speed unless slow-down is on
    effRatio = st_d.slowEn ? st_d.ratio : 3'h0;
    // divider: ratio only taken at a period boundary
    if (st_q.divCnt == 7'h00) begin
      st_d.cpuEn = 1'b1;
      st_d.actRatio = effRatio;
      st_d.divCnt = divTop(effRatio);
    end else begin
      st_d.cpuEn = 1'b0;
      st_d.divCnt = st_q.divCnt - 7'h01;
    end
    // gate bits, absent modules held gated
    if (wrGate) begin
      st_d.gate = regWdata[NUM_MODS-1:0] | ~presMask;
    end
    // module enable lags the gate register by one cycle
    st_d.modEn = ~st_q.gate & presMask & modCtrlOn;
    // read data, unmapped reads zero
    st_d.rdata = 16'h0000;
    if (regHit(regRe, regAddr, cdmcg_pkg::ADDR_DIV)) begin
      st_d.rdata[cdmcg_pkg::BIT_FAST_IRQ] = st_q.fastOnIrq;
      st_d.rdata[cdmcg_pkg::BIT_SLOW_EN] = st_q.slowEn;
      st_d.rdata[cdmcg_pkg::BIT_RATIO_HI:cdmcg_pkg::BIT_RATIO_LO] = st_q.ratio;
    end else if (regHit(regRe, regAddr, cdmcg_pkg::ADDR_GATE)) begin
      st_d.rdata[NUM_MODS-1:0] = st_q.gate;
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      st_q.fastOnIrq <= 1'b0;
      st_q.slowEn <= 1'b0;
      st_q.ratio <= cdmcg_pkg::RST_RATIO;
      st_q.actRatio <= cdmcg_pkg::RST_RATIO;
      st_q.divCnt <= cdmcg_pkg::RST_COUNT;
      st_q.cpuEn <= 1'b0;
      st_q.perEn <= 1'b0;
      st_q.gate <= ~presMask;
      st_q.modEn <= '0;
      st_q.rdata <= 16'h0000;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from flops
  assign regRdata = st_q.rdata;
  assign cpuClkEn = st_q.cpuEn;
  assign periphClkEn = st_q.perEn;
  assign modClkEn = st_q.modEn;
  assign modRegOk = st_q.modEn;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  sequence seqGateSet0;
    wrGate && regWdata[0] && presMask[0];
  endsequence

  sequence seqGateClr0;
    wrGate && !regWdata[0] && presMask[0] && modCtrlOn[0];
  endsequence

  // ------------------------------------------------------------
  // reset checks
  // ------------------------------------------------------------
  property pResetFull;
    $past(srst) |-> st_q.actRatio == 3'h0 && st_q.divCnt == 7'h00;
  endproperty
  // reset leaves the divider at 1:1 with an empty count
  chk_reset_fullspeed: assert property (pResetFull)
    else $error("cpu ratio not 1:1 after reset");

  // gate bits come up cleared for present modules
  chk_gate_reset: assert property ($past(srst) |-> st_q.gate == ~presMask)
    else $error("gate bits not cleared at reset");

  // module enables are low straight after reset
  chk_mod_reset: assert property ($past(srst) |-> modClkEn == '0)
    else $error("module enabled during reset");

  // peripheral clock runs every cycle once out of reset
  chk_per_full: assert property (!$past(srst) |-> periphClkEn)
    else $error("peripheral clock enable dropped");

  // ------------------------------------------------------------
  // register port checks
  // ------------------------------------------------------------
  property pSlowWrite;
    wrDiv && !wakeIrq |=> st_q.slowEn == $past(regWdata[11]);
  endproperty
  // slow-down enable stored unless a wake clears it
  chk_slow_write: assert property (pSlowWrite)
    else $error("slow-down enable not stored");

  property pRatioWrite;
    wrDiv |=> st_q.ratio == $past(regWdata[14:12]);
  endproperty
  // ratio field stored on every write
  chk_ratio_write: assert property (pRatioWrite)
    else $error("ratio field not stored");

  property pWakeBitWrite;
    wrDiv |=> st_q.fastOnIrq == $past(regWdata[15]);
  endproperty
  // wake-on-interrupt bit stored on every write
  chk_wake_bit_write: assert property (pWakeBitWrite)
    else $error("wake bit not stored");

  property pGateWrite;
    wrGate |=> st_q.gate == ($past(regWdata[NUM_MODS-1:0]) | ~presMask);
  endproperty
  // gate write lands, absent modules stay gated
  chk_gate_write: assert property (pGateWrite)
    else $error("gate bits not stored");

  // gate bits only move on a gate write
  chk_gate_hold: assert property (!wrGate |=> $stable(st_q.gate))
    else $error("gate bits changed without write");

  property pRatioRead;
    regRe && regAddr == cdmcg_pkg::ADDR_DIV
      |=> regRdata[14:12] == $past(st_q.ratio) && regRdata[11] == $past(st_q.slowEn);
  endproperty
  // divider register reads back its ratio and slow-down enable fields
  chk_ratio_read: assert property (pRatioRead)
    else $error("divider register read wrong");

  property pGateRead;
    regRe && regAddr == cdmcg_pkg::ADDR_GATE |=> regRdata[NUM_MODS-1:0] == $past(st_q.gate);
  endproperty
  // gate register reads back its bits
  chk_gate_read: assert property (pGateRead)
    else $error("gate register read wrong");

  property pUnmappedRead;
    regRe && regAddr != cdmcg_pkg::ADDR_DIV && regAddr != cdmcg_pkg::ADDR_GATE
      |=> regRdata == 16'h0000;
  endproperty
  // unmapped reads return zero
  chk_unmapped_read: assert property (pUnmappedRead)
    else $error("unmapped read not zero");

  // ------------------------------------------------------------
  // divider checks
  // ------------------------------------------------------------
  property pFullRate;
    st_q.actRatio == 3'h0 && st_q.divCnt == 7'h00 |=> cpuClkEn && periphClkEn;
  endproperty
  // at 1:1 both enables pulse every cycle
  chk_full_rate: assert property (pFullRate)
    else $error("full rate clock missing");

  property pDivTwo;
    cpuClkEn && st_q.actRatio == 3'h1 |=> !cpuClkEn ##1 cpuClkEn;
  endproperty
  // divide by two period
  chk_div_by_two: assert property (pDivTwo)
    else $error("divide by two period wrong");

  property pDivFour;
    cpuClkEn && st_q.actRatio == 3'h2 |=> !cpuClkEn [*3] ##1 cpuClkEn;
  endproperty
  // divide by four period
  chk_div_by_four: assert property (pDivFour)
    else $error("divide by four period wrong");

  property pDivEight;
    cpuClkEn && st_q.actRatio == 3'h3 |=> !cpuClkEn [*7] ##1 cpuClkEn;
  endproperty
  // divide by eight period
  chk_div_by_eight: assert property (pDivEight)
    else $error("divide by eight period wrong");

  property pDivSixteen;
    cpuClkEn && st_q.actRatio == 3'h4 |=> !cpuClkEn [*8] ##1 !cpuClkEn [*7] ##1 cpuClkEn;
  endproperty
  // divide by sixteen period
  chk_div_by_16: assert property (pDivSixteen)
    else $error("divide by sixteen period wrong");

  // long periods, gaps covered by the gap check
  chk_div_32: assert property (cpuClkEn && st_q.actRatio == 3'h5 |-> ##32 cpuClkEn)
    else $error("divide by 32 period wrong");

  // divide by 64 period
  chk_div_64: assert property (cpuClkEn && st_q.actRatio == 3'h6 |-> ##64 cpuClkEn)
    else $error("divide by 64 period wrong");

  // divide by 128 period
  chk_div_128: assert property (cpuClkEn && st_q.actRatio == 3'h7 |-> ##128 cpuClkEn)
    else $error("divide by 128 period wrong");

  // no cpu pulse while the count runs
  chk_cpu_gap: assert property (st_q.divCnt != 7'h00 |=> !cpuClkEn)
    else $error("cpu pulse inside a period");

  // a pulse always follows a boundary
  chk_boundary_pulse: assert property (st_q.divCnt == 7'h00 |=> cpuClkEn)
    else $error("cpu pulse missing at boundary");

  // a new period loads the count for its ratio
  chk_count_load: assert property (cpuClkEn |-> st_q.divCnt == divTop(st_q.actRatio))
    else $error("period count wrong");

  // ratio in force only moves at a boundary
  chk_ratio_hold: assert property (st_q.divCnt != 7'h00 |=> $stable(st_q.actRatio))
    else $error("ratio changed mid period");

  property pSlowOff;
    !st_q.slowEn && !wrDiv && st_q.divCnt == 7'h00 |=> st_q.actRatio == 3'h0;
  endproperty
  // slow-down off means 1:1 from the next boundary
  chk_slow_off: assert property (pSlowOff)
    else $error("ratio used while slow-down off");

  property pIrqWake;
    irqEvent && st_q.fastOnIrq && st_q.slowEn |=> !st_q.slowEn;
  endproperty
  // interrupt with wake bit ends slow-down
  chk_irq_wake: assert property (pIrqWake)
    else $error("interrupt did not restore full speed");

  // wake beats the slow-down enable of a same-cycle divider write
  chk_wake_wins: assert property (wakeIrq && wrDiv |=> !st_q.slowEn)
    else $error("write overrode interrupt wake");

  property pIrqIgnored;
    irqEvent && !st_q.fastOnIrq && !wrDiv |=> $stable(st_q.slowEn) && $stable(st_q.ratio);
  endproperty
  // without the wake bit interrupts change nothing
  chk_irq_ignored: assert property (pIrqIgnored)
    else $error("interrupt changed slow-down without wake bit");

  // gate set stops the module two edges on
  chk_gate_off: assert property (seqGateSet0 |=> ##1 !modClkEn[0])
    else $error("module not disabled one cycle after gate");

  // register access follows the gate too
  chk_regok_off: assert property (seqGateSet0 |=> ##1 !modRegOk[0])
    else $error("module registers live after gate");

  property pGateOn;
    seqGateClr0 ##1 modCtrlOn[0] |=> modClkEn[0];
  endproperty
  // gate clear restarts a module whose control allows it
  chk_gate_on: assert property (pGateOn)
    else $error("module not re-enabled one cycle after ungate");

  // own control off keeps the module stopped
  chk_ctrl_off: assert property (!modCtrlOn[0] |=> !modClkEn[0])
    else $error("module enabled without own control");

  // absent modules never run
  chk_absent_off: assert property ((modClkEn & ~presMask) == '0)
    else $error("absent module enabled");

  // register access and clock enable agree
  chk_regok_match: assert property (modRegOk == modClkEn)
    else $error("register access and clock differ");

endmodule

`default_nettype wire

// ### test/cdmcg_partner.sv
// Purpose: cpu core and peripheral side, counts the clock enables it gets
// Assumes: enables are sampled on the rising clk edge
// Notes: counters free-run, the bench takes differences over windows
`timescale 1ns/1ps
`default_nettype none

module cdmcg_partner (
  // clock
  input wire logic clk,
  // enables from the block
  input wire logic cpuClkEn,
  input wire logic periphClkEn,
  // tick counts
  output var int cpuTicks,
  output var int perTicks
);
  int cpuN = 0;
  int perN = 0;

  // one cpu or peripheral cycle per enable pulse
  always @(posedge clk) begin
    if (cpuClkEn === 1'b1) begin
      cpuN <= cpuN + 1;
    end
    if (periphClkEn === 1'b1) begin
      perN <= perN + 1;
    end
  end

  // counts out
  assign cpuTicks = cpuN;
  assign perTicks = perN;
endmodule

`default_nettype wire

// ### test/tb.sv
// Purpose: self-checking bench for the slow-down and clock gate block
// Assumes: 40 MHz clock, reset held 8 cycles, top gate bit absent
// Notes: cpu ticks counted over windows that hold whole cpu periods
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin nCompared++; if ((g) !== (e)) begin errCount++; \
  $display("ERROR %s exp %h got %h", nm, e, g); end end

module tb;
  localparam logic [15:0] PRES = 16'h7fff; // top module absent
  logic clk = 1'b0, srst = 1'b1, regWe = 1'b0, regRe = 1'b0, irqEvent = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [15:0] regWdata = 16'h0000, modCtrlOn, regRdata, modClkEn, modRegOk, mEn;
  logic cpuClkEn, periphClkEn;
  int cpuTicks, perTicks, mDiv = 0, mGate = 0, errCount = 0, nCompared = 0, cyc = 0;

  cdmcg_top #(.NUM_MODS(16), .PRESENT(PRES)) dut (.clk(clk), .srst(srst), .regAddr(regAddr),
    .regWdata(regWdata), .regWe(regWe), .regRe(regRe), .regRdata(regRdata),
    .irqEvent(irqEvent), .modCtrlOn(modCtrlOn), .cpuClkEn(cpuClkEn),
    .periphClkEn(periphClkEn), .modClkEn(modClkEn), .modRegOk(modRegOk));
  cdmcg_partner part (.clk(clk), .cpuClkEn(cpuClkEn), .periphClkEn(periphClkEn),
    .cpuTicks(cpuTicks), .perTicks(perTicks));

  // ------------------------------------------------------------
  // bus tasks and model
  // ------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWe <= 1'b1;
    @(posedge clk);
    regWe <= 1'b0;
    if (a == 4'h0) begin
      mDiv = d & 16'hf800;
    end
    if (a == 4'h1) begin
      mGate = d;
    end
  endtask

  task automatic rd(input logic [3:0] a);
    logic [15:0] e;
    e = (a == 4'h0) ? mDiv[15:0] : (a == 4'h1) ? (mGate[15:0] | ~PRES) : 16'h0000;
    @(posedge clk);
    regAddr <= a;
    regRe <= 1'b1;
    @(posedge clk);
    regRe <= 1'b0;
    #1;
    `CHK("regRdata", e, regRdata)
  endtask

  // settle past a period boundary, then count over 256 cycles
  task automatic ticks(input int r);
    int c0, p0;
    repeat (130) @(posedge clk);
    #1;
    c0 = cpuTicks;
    p0 = perTicks;
    repeat (256) @(posedge clk);
    #1;
    `CHK("cpuTicks", 256 >> r, cpuTicks - c0)
    `CHK("perTicks", 256, perTicks - p0)
  endtask

  task automatic irq();
    @(posedge clk);
    irqEvent <= 1'b1;
    @(posedge clk);
    irqEvent <= 1'b0;
    if (mDiv[15]) begin
      mDiv[11] = 1'b0;
    end
  endtask

  // gate write, old enables one cycle, new ones the next
  task automatic gate(input logic [15:0] m);
    logic [15:0] e;
    e = PRES & ~m & modCtrlOn;
    wr(4'h1, m);
    #1;
    `CHK("modClkEn early", mEn, modClkEn)
    @(posedge clk);
    #1;
    `CHK("modClkEn", e, modClkEn)
    `CHK("modRegOk", e, modRegOk)
    mEn = e;
    rd(4'h1);
  endtask

  task automatic giveVerdict();
    $display("compared %0d errors %0d", nCompared, errCount);
    if (errCount == 0 && nCompared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // clock, timeout and main sequence
  // ------------------------------------------------------------
  initial begin
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errCount++;
      giveVerdict();
    end
  end

  initial begin
    void'($urandom(32'h6ace));
    modCtrlOn <= 16'($urandom());
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    mEn = PRES & modCtrlOn;
    @(posedge clk);
    #1;
    `CHK("cpuClkEn", 1'b1, cpuClkEn)
    rd(4'h0);
    rd(4'h1);
    rd(4'h5);
    ticks(0);
    for (int r = 0; r < 8; r++) begin
      wr(4'h0, {1'b0, r[2:0], 1'b1, 11'h000});
      rd(4'h0);
      ticks(r);
    end
    wr(4'h0, 16'h5000);
    ticks(0);
    wr(4'h0, 16'h3800);
    irq();
    rd(4'h0);
    ticks(3);
    wr(4'h0, 16'hb800);
    irq();
    rd(4'h0);
    ticks(0);
    gate(16'($urandom()));
    gate(16'h0000);
    gate(16'hffff);
    giveVerdict();
  end
endmodule

`default_nettype wire
